// *** common/bce_defs.vh ***
`ifndef BCE_DEFS_VH
`define BCE_DEFS_VH

// Engine states.
`define BCE_ST_IDLE 2'h0
`define BCE_ST_KEXP 2'h1
`define BCE_ST_AES  2'h2
`define BCE_ST_DES  2'h3

// Algorithm select and key length codes.
`define BCE_ALG_TDES 1'h0
`define BCE_ALG_AES  1'h1
`define BCE_KS_112   2'h0
`define BCE_KS_168   2'h1
`define BCE_KS_128   2'h0
`define BCE_KS_192   2'h1
`define BCE_KS_256   2'h2

// Key words per AES key length, round key storage and schedule constants.
`define BCE_NK_128    4'h4
`define BCE_NK_192    4'h6
`define BCE_NK_256    4'h8
`define BCE_NR_EXTRA  4'h6
`define BCE_AES_WORDS 60
`define BCE_RCON_INIT 8'h01
`define BCE_AES_POLY  8'h1b
`define BCE_AES_AFF   8'h63
`define BCE_AES_IAFF  8'h05
`define BCE_MIX_ENC   32'h02030101
`define BCE_MIX_DEC   32'h0e0b0d09

// Last round index of one single-key pass.
`define BCE_DES_LAST 4'hf

// Bit tables, one byte per entry, first entry in the top byte.
// Long tables are built from sized pieces so that no literal is split across lines.
`define BCE_DES_P   {200'h100714151d0c1c11010f171a05121f0a0208180e201b030913, \
56'h0d1e06160b0419}
`define BCE_DES_PC1 {64'h3931292119110901, \
224'h3a322a221a120a023b332b231b130b033c342c243f372f271f170f07, \
160'h3e362e261e160e063d352d251d150d051c140c04}
`define BCE_DES_PC2 {192'h0e110b180105031c0f06150a17130c041a0810071b140d02, \
144'h29341f252f371e28332d21302c3127382235, \
32'h2e2a3224, \
16'h1d20}

// Substitution boxes, 4 rows of 16 nibbles each, first box at the top.
`define BCE_DES_SBOX {256'he4d12fb83a6c59070f74e2d1a6cb953841e8d62bfc973a50fc8249175b3ea06d, \
256'hf18e6b34972dc05a3d47f28ec01a69b50e7ba4d158c6932fd8a13f42b67c05e9, \
256'ha09e63f51dc7b428d709346a285ecbf1d6498f30b12c5ae71ad069874fe3b52c, \
256'h7de3069a1285bc4fd8b56f03472c1ae9a690cb7df13e52843f06a1d8945bc72e, \
256'h2c417ab6853fd0e9eb2c47d150fa3986421bad78f9c5630eb8c71e2d6f09a453, \
256'hc1af92680d34e75baf427c9561de0b389ef528c3704a1db6432c95fabe17608d, \
256'h4b2ef08d3c975a61d0b7491ae35c2f8614bdc37eaf6805926bd814a7950fe23c, \
256'hd2846fb1a93e50c71fd8a374c56b0e927b419ce206adf35821e74a8dfc90356b}

`endif

// *** hw/bce_top.v ***
`timescale 1ns/1ns
`include "bce_defs.vh"

// What this block does
// [R01] Triple DES encrypts and decrypts single blocks, codebook only, 112 or 168 bit keys.
// [R02] Two-key option repeats the first subkey as the third; three-key uses all three.
// [R03] AES encrypts and decrypts single blocks, codebook only, 128, 192 or 256 bit keys.
// [R04] Every key load overwrites the whole stored key and round key storage.
// [R05] Reset fills the key storage with random content from the entropy input.
// [R06] Blocks are 64 bits for DES, 128 for AES; done marks a readable result.
module bce_top (
	input  wire         clk,
	input  wire         reset,
	input  wire [255:0] rnd_in,
	input  wire         key_load,
	input  wire         key_algo,
	input  wire [1:0]   key_size,
	input  wire [255:0] key_in,
	input  wire         start,
	input  wire         decrypt,
	input  wire [127:0] data_in,
	output wire         key_ready,
	output wire         busy,
	output wire         done,
	output wire [127:0] data_out
);
	localparam [255:0]  DES_P   = `BCE_DES_P;
	localparam [447:0]  DES_PC1 = `BCE_DES_PC1;
	localparam [383:0]  DES_PC2 = `BCE_DES_PC2;
	localparam [2047:0] DES_SB  = `BCE_DES_SBOX;

	function [7:0] xt(input [7:0] b);
		xt = {b[6:0], 1'b0} ^ (b[7] ? `BCE_AES_POLY : 8'h00);
	endfunction

	function [7:0] gm(input [7:0] a, input [7:0] b);
		reg [7:0] x, p;
		integer i;
		begin
			p = 8'h00;
			x = a;
			for (i = 0; i < 8; i = i + 1) begin
				if (b[i]) p = p ^ x;
				x = xt(x);
			end
			gm = p;
		end
	endfunction

	// Field inverse as a to the power 254; zero maps to zero.
	function [7:0] ginv(input [7:0] a);
		reg [7:0] t, r;
		integer i;
		begin
			r = 8'h01;
			t = a;
			for (i = 0; i < 7; i = i + 1) begin
				t = gm(t, t);
				r = gm(r, t);
			end
			ginv = r;
		end
	endfunction

	function [7:0] rl(input [7:0] b, input [2:0] n);
		reg [15:0] d;
		begin
			d = {b, b} << n;
			rl = d[15:8];
		end
	endfunction

	// Byte substitution computed, not tabled, to keep the area of tables down.
	function [7:0] sbx(input [7:0] b, input inv);
		reg [7:0] y;
		begin
			if (inv) begin
				y = rl(b, 3'd1) ^ rl(b, 3'd3) ^ rl(b, 3'd6) ^ `BCE_AES_IAFF;
				sbx = ginv(y);
			end else begin
				y = ginv(b);
				sbx = y ^ rl(y, 3'd1) ^ rl(y, 3'd2) ^ rl(y, 3'd3) ^ rl(y, 3'd4) ^ `BCE_AES_AFF;
			end
		end
	endfunction

	function [31:0] subw(input [31:0] w);
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1)
				subw[31-8*i -: 8] = sbx(w[31-8*i -: 8], 1'b0);
		end
	endfunction

	// One AES round; the inverse order follows the standard inverse cipher.
	function [127:0] aes_rnd(input [127:0] s, input [127:0] k, input inv, input last);
		reg [127:0] t, u;
		reg [31:0]  cf;
		reg [7:0]   acc;
		integer c, r, i, src;
		begin
			cf = inv ? `BCE_MIX_DEC : `BCE_MIX_ENC;
			for (c = 0; c < 4; c = c + 1)
				for (r = 0; r < 4; r = r + 1) begin
					src = inv ? (c - r + 4) % 4 : (c + r) % 4;
					t[127-8*(4*c+r) -: 8] = sbx(s[127-8*(4*src+r) -: 8], inv);
				end
			if (inv) t = t ^ k;
			u = t;
			for (c = 0; c < 4; c = c + 1)
				for (r = 0; r < 4; r = r + 1) begin
					acc = 8'h00;
					for (i = 0; i < 4; i = i + 1)
						acc = acc ^ gm(cf[31-8*((i-r+4)%4) -: 8], t[127-8*(4*c+i) -: 8]);
					if (!last) u[127-8*(4*c+r) -: 8] = acc;
				end
			aes_rnd = inv ? u : u ^ k;
		end
	endfunction

	// Initial permutation, or its inverse when inv is set.
	function [63:0] des_ip(input [63:0] x, input inv);
		integer j, n;
		begin
			for (j = 0; j < 64; j = j + 1) begin
				n = ((j / 8) < 4 ? 58 + 2 * (j / 8) : 49 + 2 * (j / 8)) - 8 * (j % 8);
				if (inv) des_ip[64-n] = x[63-j];
				else des_ip[63-j] = x[64-n];
			end
		end
	endfunction

	function [55:0] des_pc1(input [63:0] k);
		integer j;
		begin
			for (j = 0; j < 56; j = j + 1)
				des_pc1[55-j] = k[64-DES_PC1[8*(55-j) +: 8]];
		end
	endfunction

	function [47:0] des_pc2(input [55:0] cd);
		integer j;
		begin
			for (j = 0; j < 48; j = j + 1)
				des_pc2[47-j] = cd[56-DES_PC2[8*(47-j) +: 8]];
		end
	endfunction

	// Round function: expand, mix key, substitute, permute.
	function [31:0] des_f(input [31:0] r, input [47:0] k);
		reg [47:0] e;
		reg [31:0] o;
		reg [5:0]  b;
		integer j, s, n;
		begin
			for (j = 0; j < 48; j = j + 1)
				e[47-j] = r[31-((4*(j/6) + (j%6) + 31) % 32)];
			e = e ^ k;
			for (s = 0; s < 8; s = s + 1) begin
				b = e[47-6*s -: 6];
				n = s * 64 + {b[5], b[0]} * 16 + b[4:1];
				o[31-4*s -: 4] = DES_SB[4*(511-n) +: 4];
			end
			for (j = 0; j < 32; j = j + 1)
				des_f[31-j] = o[32-DES_P[8*(31-j) +: 8]];
		end
	endfunction

	// Rotates both 28-bit key halves by one or two places.
	function [55:0] rot(input [55:0] cd, input two, input right);
		reg [27:0] c, d;
		begin
			c = cd[55:28];
			d = cd[27:0];
			if (right && two) rot = {c[1:0], c[27:2], d[1:0], d[27:2]};
			else if (right) rot = {c[0], c[27:1], d[0], d[27:1]};
			else if (two) rot = {c[25:0], c[27:26], d[25:0], d[27:26]};
			else rot = {c[26:0], c[27], d[26:0], d[27]};
		end
	endfunction

	function two_sh(input [3:0] r);
		two_sh = !(r == 4'd0 || r == 4'd1 || r == 4'd8 || r == 4'd15);
	endfunction

	reg  [255:0] key_q;
	reg  [31:0]  w_q [0:`BCE_AES_WORDS-1];
	reg  [1:0]   st_q;
	reg          algo_q, two_key_q, dec_q, key_ok_q, busy_q, done_q;
	reg  [3:0]   nk_q, ar_q, dr_q;
	reg  [5:0]   ki_q;
	reg  [2:0]   kc_q;
	reg  [7:0]   rcon_q;
	reg  [127:0] s_q, dout_q;
	reg  [31:0]  dl_q, drr_q;
	reg  [55:0]  cd_q;
	reg  [1:0]   dst_q;

	reg  [31:0]  ktmp;
	reg  [127:0] aes_k, aes_k0, aes_nx;
	reg  [55:0]  cdu, cdn;
	reg  [31:0]  des_nr;
	reg  [63:0]  des_fin, k1, k2, k3;
	reg          sdec, alast;
	reg  [3:0]   nk_new;
	integer      i;

	wire [3:0] nr_w   = nk_q + `BCE_NR_EXTRA;
	wire [5:0] klast  = {nr_w, 2'b00} + 6'd3;
	wire [5:0] rkb    = {ar_q, 2'b00};
	wire [5:0] rk0    = decrypt ? {nr_w, 2'b00} : 6'd0;
	wire [1:0] nxt_st = dst_q + 2'd1;

	// Selects the DES single key for a pass from the stored key.
	function [63:0] dkey(input [1:0] stg, input dec, input [63:0] a, input [63:0] b,
		input [63:0] c);
		reg [1:0] n;
		begin
			n = dec ? 2'd2 - stg : stg;
			dkey = (n == 2'd0) ? a : (n == 2'd1) ? b : c;
		end
	endfunction

	// Round datapaths for both algorithms and the key schedule word.
	always @* begin
		k1 = key_q[255:192];
		k2 = key_q[191:128];
		k3 = two_key_q ? key_q[255:192] : key_q[127:64]; // [R02]
		aes_k = {w_q[rkb], w_q[rkb+6'd1], w_q[rkb+6'd2], w_q[rkb+6'd3]};
		aes_k0 = {w_q[rk0], w_q[rk0+6'd1], w_q[rk0+6'd2], w_q[rk0+6'd3]};
		alast = dec_q ? (ar_q == 4'd0) : (ar_q == nr_w);
		aes_nx = aes_rnd(s_q, aes_k, dec_q, alast); // [R03]
		sdec = dec_q ^ (dst_q == 2'd1); // [R01]
		cdu = sdec ? cd_q : rot(cd_q, two_sh(dr_q), 1'b0);
		cdn = sdec ? rot(cd_q, two_sh(`BCE_DES_LAST - dr_q), 1'b1) : cdu;
		des_nr = dl_q ^ des_f(drr_q, des_pc2(cdu));
		des_fin = des_ip({des_nr, drr_q}, 1'b1);
		ktmp = w_q[ki_q-6'd1];
		if (kc_q == 3'd0) ktmp = subw({ktmp[23:0], ktmp[31:24]}) ^ {rcon_q, 24'h000000};
		else if (nk_q == `BCE_NK_256 && kc_q == 3'd4) ktmp = subw(ktmp);
		case (key_size)
			`BCE_KS_128: nk_new = `BCE_NK_128;
			`BCE_KS_192: nk_new = `BCE_NK_192;
			default:     nk_new = `BCE_NK_256;
		endcase
	end

	// Control, key storage and data registers.
	always @(posedge clk) begin
		if (reset) begin
			key_q <= rnd_in; // [R05]
			for (i = 0; i < `BCE_AES_WORDS; i = i + 1)
				w_q[i] <= rnd_in[32*(i%8) +: 32]; // [R05]
			st_q <= `BCE_ST_IDLE;
			{algo_q, two_key_q, dec_q, key_ok_q, busy_q, done_q} <= 6'h00;
			{nk_q, ar_q, dr_q, ki_q, kc_q, rcon_q, dst_q} <= 31'h00000000;
			{s_q, dout_q, dl_q, drr_q, cd_q} <= 376'h0;
		end else begin
			done_q <= 1'b0;
			if (key_load) begin
				key_q <= key_in; // [R04]
				for (i = 0; i < `BCE_AES_WORDS; i = i + 1)
					w_q[i] <= (key_algo == `BCE_ALG_AES && i < nk_new) ?
						key_in[255-32*i -: 32] : 32'h00000000; // [R04]
				algo_q <= key_algo;
				two_key_q <= (key_size == `BCE_KS_112); // [R02]
				nk_q <= nk_new;
				ki_q <= {2'b00, nk_new};
				kc_q <= 3'd0;
				rcon_q <= `BCE_RCON_INIT;
				busy_q <= 1'b0;
				key_ok_q <= (key_algo == `BCE_ALG_TDES);
				st_q <= (key_algo == `BCE_ALG_AES) ? `BCE_ST_KEXP : `BCE_ST_IDLE;
			end else begin
				case (st_q)
					`BCE_ST_IDLE: begin
						if (start && key_ok_q) begin
							dec_q <= decrypt;
							busy_q <= 1'b1;
							if (algo_q == `BCE_ALG_AES) begin
								s_q <= data_in ^ aes_k0; // [R06]
								ar_q <= decrypt ? nr_w - 4'd1 : 4'd1;
								st_q <= `BCE_ST_AES;
							end else begin
								{dl_q, drr_q} <= des_ip(data_in[63:0], 1'b0); // [R06]
								cd_q <= des_pc1(dkey(2'd0, decrypt, k1, k2, k3));
								dr_q <= 4'd0;
								dst_q <= 2'd0;
								st_q <= `BCE_ST_DES;
							end
						end
					end
					`BCE_ST_KEXP: begin
						w_q[ki_q] <= w_q[ki_q-{2'b00, nk_q}] ^ ktmp; // [R03]
						if (kc_q == 3'd0) rcon_q <= xt(rcon_q);
						kc_q <= (kc_q == nk_q[2:0] - 3'd1 || nk_q == `BCE_NK_256 && kc_q == 3'd7)
							? 3'd0 : kc_q + 3'd1;
						ki_q <= ki_q + 6'd1;
						if (ki_q == klast) begin
							key_ok_q <= 1'b1;
							st_q <= `BCE_ST_IDLE;
						end
					end
					`BCE_ST_AES: begin
						s_q <= aes_nx;
						ar_q <= dec_q ? ar_q - 4'd1 : ar_q + 4'd1;
						if (alast) begin
							dout_q <= aes_nx; // [R06]
							done_q <= 1'b1;
							busy_q <= 1'b0;
							st_q <= `BCE_ST_IDLE;
						end
					end
					default: begin
						dl_q <= drr_q;
						drr_q <= des_nr;
						cd_q <= cdn;
						dr_q <= dr_q + 4'd1;
						if (dr_q == `BCE_DES_LAST) begin
							{dl_q, drr_q} <= des_ip(des_fin, 1'b0);
							cd_q <= des_pc1(dkey(nxt_st, dec_q, k1, k2, k3)); // [R01]
							dst_q <= nxt_st;
							if (dst_q == 2'd2) begin
								dout_q <= {64'h0, des_fin}; // [R06]
								done_q <= 1'b1;
								busy_q <= 1'b0;
								st_q <= `BCE_ST_IDLE;
							end
						end
					end
				endcase
			end
		end
	end

	// Outputs come straight from their registers.
	assign key_ready = key_ok_q;
	assign busy      = busy_q;
	assign done      = done_q;
	assign data_out  = dout_q;
endmodule // bce_top

// *** sim/bce_top_chk.sv ***
`timescale 1ns/1ns
// Watches the engine ports for timing, refusal and key handling faults.
module bce_top_chk (
	input wire         clk,
	input wire         reset,
	input wire         key_load,
	input wire         key_algo,
	input wire [1:0]   key_size,
	input wire         start,
	input wire         key_ready,
	input wire         busy,
	input wire         done,
	input wire [127:0] data_out
);
	reg       alg_q;
	reg [1:0] size_q;
	wire      go = start && key_ready && !busy && !key_load;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Remembers the kind of the key most recently taken.
	always @(posedge clk) begin
		if (key_load) begin
			alg_q  <= key_algo;
			size_q <= key_size;
		end
	end
	property p_clear;
		$fell(reset) |-> !key_ready && !busy && !done && data_out == 128'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("state left after reset");
	property p_refuse; !key_ready && !busy |=> !busy; endproperty
	a_refuse: assert property (p_refuse) else $error("block started without a key");
	property p_tkey; key_load && !key_algo |=> key_ready; endproperty
	a_tkey: assert property (p_tkey) else $error("short key not ready");
	property p_akey;
		key_load && key_algo && key_size == 2'h0 |=>
			!key_ready[*8] ##[31:34] $rose(key_ready);
	endproperty
	a_akey: assert property (p_akey) else $error("key expansion time wrong");
	property p_go; go |=> busy; endproperty
	a_go: assert property (p_go) else $error("accepted start without busy");
	property p_adone; go && alg_q && size_q == 2'h2 |-> ##[14:15] done; endproperty
	a_adone: assert property (p_adone) else $error("long key block late");
	property p_tdone; go && !alg_q |-> ##[48:49] (done || !key_ready); endproperty
	a_tdone: assert property (p_tdone) else $error("triple block late");
	property p_pulse; done |-> !busy ##1 !done; endproperty
	a_pulse: assert property (p_pulse) else $error("done not a lone pulse");
	property p_hold; !$stable(data_out) |-> done; endproperty
	a_hold: assert property (p_hold) else $error("result moved without done");
	property p_upper; done && !alg_q |-> data_out[127:64] == 64'h0; endproperty
	a_upper: assert property (p_upper) else $error("triple result upper half set");
endmodule // bce_top_chk

bind bce_top bce_top_chk bce_top_chk_i (.clk(clk), .reset(reset), .key_load(key_load),
	.key_algo(key_algo), .key_size(key_size), .start(start), .key_ready(key_ready),
	.busy(busy), .done(done), .data_out(data_out));

// *** sim/bce_cpu.sv ***
`timescale 1ns/1ns
// Processor side: hands keys and blocks over on falling edges, then lets go of the lines.
module bce_cpu (
	input wire          clk,
	input wire          key_ready,
	input wire          done,
	input wire  [127:0] data_out,
	output reg          key_load = 1'b0,
	output reg          key_algo = 1'b0,
	output reg  [1:0]   key_size = 2'h0,
	output reg  [255:0] key_in   = 256'h0,
	output reg          start    = 1'b0,
	output reg          decrypt  = 1'b0,
	output reg  [127:0] data_in  = 128'h0
);
	// Whole key in one cycle; released lines show the inverse so no stale key is seen.
	task automatic load(input a, input [1:0] s, input [255:0] k, output ok);
		integer n;
		@(negedge clk);
		{key_algo, key_size, key_in, key_load} = {a, s, k, 1'b1};
		@(negedge clk);
		key_load = 1'b0;
		key_in = ~k;
		ok = 1'b0;
		for (n = 0; n < 80 && !ok; n++) begin
			@(posedge clk);
			#1 ok = (key_ready === 1'b1);
		end
	endtask
	// One start pulse with its block; the data lines change once it is taken.
	task automatic kick(input d, input [127:0] x);
		@(negedge clk);
		{decrypt, data_in, start} = {d, x, 1'b1};
		@(negedge clk);
		start = 1'b0;
		data_in = ~x;
	endtask
	// Starts a block and takes the result in the cycle that done marks it.
	task automatic run(input d, input [127:0] x, output [127:0] r, output ok);
		integer n;
		kick(d, x);
		ok = 1'b0;
		for (n = 0; n < 60 && !ok; n++) begin
			@(posedge clk);
			#1 ok = (done === 1'b1);
		end
		r = data_out;
	endtask
endmodule // bce_cpu

// *** sim/bce_top_tb.sv ***
`timescale 1ns/1ns
`define CHK(a, b) samples_checked++; if ((a) !== (b)) begin fails++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end
module bce_top_tb;
	localparam [127:0] PT = 128'h00112233445566778899aabbccddeeff;
	localparam [63:0]  DK = 64'h133457799bbcdff1;
	localparam [63:0]  DP = 64'h0123456789abcdef;
	localparam [63:0]  DC = 64'h85e813540f0ab405;
	localparam [255:0] K3 = 256'h000102030405060708090a0b0c0d0e0f101112131415161718191a1b1c1d1e1f;
	localparam [127:0] C3 = 128'h8ea2b7ca516745bfeafc49904b496089;
	reg         clk    = 1'b0;
	reg         reset  = 1'b1;
	reg [255:0] rnd_in = {8{32'h5ac3e1f0}};
	wire        key_load, key_algo, start, decrypt, key_ready, busy, done;
	wire [1:0]  key_size;
	wire [255:0] key_in;
	wire [127:0] data_in, data_out;
	integer     fails = 0, samples_checked = 0, dones = 0, n;
	reg         ok;
	reg [127:0] r;
	bce_top bce_top_i (.clk(clk), .reset(reset), .rnd_in(rnd_in), .key_load(key_load),
		.key_algo(key_algo), .key_size(key_size), .key_in(key_in), .start(start),
		.decrypt(decrypt), .data_in(data_in), .key_ready(key_ready), .busy(busy),
		.done(done), .data_out(data_out));
	bce_cpu bce_cpu_i (.clk(clk), .key_ready(key_ready), .done(done), .data_out(data_out),
		.key_load(key_load), .key_algo(key_algo), .key_size(key_size), .key_in(key_in),
		.start(start), .decrypt(decrypt), .data_in(data_in));
	// Clock and a count of result pulses.
	always #50 clk = ~clk;
	always @(posedge clk) #1 if (done === 1'b1) dones++;
	task conclude;
		$display("checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// A wait that ran out ends the run.
	task need(input v);
		if (v !== 1'b1) begin
			fails++;
			$display("unexpected at %0t: no answer", $time);
			conclude;
		end
	endtask
	// Freshly reset engine holds no usable key and ignores start.
	task s_cold;
		`CHK(key_ready, 1'b0);
		`CHK(data_out, 128'h0);
		bce_cpu_i.run(1'b0, PT, r, ok);
		`CHK(ok, 1'b0);
	endtask
	// Encrypts and decrypts one block under a key that replaces the previous one.
	task s_aes(input [1:0] s, input [255:0] k, input [127:0] c);
		bce_cpu_i.load(1'b1, s, k, ok);
		need(ok);
		bce_cpu_i.run(1'b0, PT, r, ok);
		need(ok);
		`CHK(r, c);
		bce_cpu_i.run(1'b1, c, r, ok);
		need(ok);
		`CHK(r, PT);
	endtask
	// One triple block under the given key kind; returns the result.
	task s_des(input [1:0] s, input [255:0] k, input d, input [63:0] x);
		bce_cpu_i.load(1'b0, s, k, ok);
		need(ok);
		bce_cpu_i.run(d, {64'h0, x}, r, ok);
		need(ok);
	endtask
	// A key load in mid-block aborts it without a result.
	task s_abort;
		s_des(2'h1, {DK, DK, DK, 64'h0}, 1'b0, DP);
		bce_cpu_i.kick(1'b0, {64'h0, DP});
		repeat (5) @(negedge clk);
		n = dones;
		bce_cpu_i.load(1'b1, 2'h2, K3, ok);
		need(ok);
		`CHK(dones, n);
		bce_cpu_i.run(1'b0, PT, r, ok);
		need(ok);
		`CHK(r, C3);
	endtask
	initial begin
		repeat (5) @(negedge clk);
		reset = 1'b0;
		s_cold;
		s_aes(2'h2, K3, C3);
		s_aes(2'h1, {K3[255:64], 64'h0}, 128'hdda97ca4864cdfe06eaf70a0ec0d7191);
		s_aes(2'h0, {K3[255:128], 128'h0}, 128'h69c4e0d86a7b0430d8cdb78070b4c55a);
		s_des(2'h1, {DK, DK, DK, 64'h0}, 1'b0, DP);
		`CHK(r, {64'h0, DC});
		s_des(2'h1, {DK, DK, DK, 64'h0}, 1'b1, DC);
		`CHK(r, {64'h0, DP});
		s_des(2'h0, {DK, DK, ~DK, 64'h0}, 1'b0, DP);
		`CHK(r, {64'h0, DC});
		s_des(2'h1, {DK, DK, ~DK, 64'h0}, 1'b0, DP);
		`CHK(r[63:0] !== DC, 1'b1);
		s_abort;
		@(negedge clk);
		reset = 1'b1;
		repeat (5) @(negedge clk);
		reset = 1'b0;
		s_cold;
		conclude;
	end
endmodule // bce_top_tb
